// ### core/lvsoc_map.svh
// Purpose: offsets, fields, reset values and word codes of the serial
//   output and clock generator block
// Assumes: included by its bare name
// Notes: bare constants only, no logic
// Notes on behaviour
// - Thirty-two lanes, two bits per master period
// - Eight-bit converter words shifted out continuously
// - One is positive pair, zero negative
// - Register 72 bits 3:0 set drive
// - Drive code maps linearly 1.26 to 7.56 mA
// - Sync lane carries frame, line, idle, address
// - Sync words delayed to match data latency
// - Forwarded clock edge-aligned with all lanes
// - Serializer clock copies the master clock
// - Checksum clock is master over four
// - Load pulse quarter rate, one-eighth duty
// - Converter clock is master over eight
// - Sensor clock quarter rate, edges delayed
// - Second converter clock eighth rate, delayed
// - Register 65 sets both delays, fifteen steps
// - One step is half a master period
`ifndef LVSOC_MAP_SVH
`define LVSOC_MAP_SVH
`define LVSOC_REG_SKEW 7'h41
`define LVSOC_REG_DRIVE 7'h48
`define LVSOC_REG_STATUS 7'h49
`define LVSOC_SKEW_RST 8'h77
`define LVSOC_DRIVE_RST 8'h05
`define LVSOC_SKEW_MAX 4'he
`define LVSOC_DRV_BASE_UA 13'h04ec
`define LVSOC_DRV_STEP_UA 13'h01a4
`define LVSOC_SYNC_LAT 11
`define LVSOC_FIFO_DEPTH 8
`define LVSOC_W_FRAME 8'hf0
`define LVSOC_W_LINE_BEGIN 8'hc3
`define LVSOC_W_LINE_END 8'h3c
`define LVSOC_W_IDLE_FIRST 8'h55
`define LVSOC_W_IDLE_SECOND 8'haa
`define LVSOC_W_DATA_IDLE 8'h00
`endif

// ### core/lvsoc_pkg.sv
// Purpose: types shared by the serial output block
// Assumes: nothing
// Notes: numbers live in lvsoc_map.svh
package lvsoc_pkg;
	// What the sequencer asks the sync lane to send
	typedef enum logic [2:0] {
		LVSOC_FRAME = 3'b000,
		LVSOC_LINE_BEGIN = 3'b001,
		LVSOC_LINE_END = 3'b010,
		LVSOC_IDLE_FIRST = 3'b011,
		LVSOC_IDLE_SECOND = 3'b100,
		LVSOC_LINE_ADDR = 3'b101
	} lvsoc_sync_kind_t;

	typedef struct packed {
		lvsoc_sync_kind_t kind;
		logic [7:0] addr;
	} lvsoc_seq_t;

	// Derived clock levels driven out of the block
	typedef struct packed {
		logic ser;
		logic crc;
		logic load;
		logic adc;
		logic sensor;
		logic adc_dly;
	} lvsoc_clks_t;

	typedef enum logic [1:0] {
		LVSOC_SPI_IDLE = 2'b00,
		LVSOC_SPI_HEAD = 2'b01,
		LVSOC_SPI_DATA = 2'b10
	} lvsoc_spi_st_t;
endpackage : lvsoc_pkg

// ### core/lvsoc_fifo.sv
// Purpose: word buffer between converters and serializers
// Assumes: one clock, DEPTH a power of two
// Notes: in_ready is registered so the source sees a flop
`timescale 1ns/100ps
module lvsoc_fifo #(
	parameter int W = 256,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad
			$error("lvsoc_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	// Handshakes; push only while the registered ready is high
	wire do_push = in_valid_i && in_ready_o;
	wire do_pop = out_valid_o && out_ready_i;
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];
	assign level_o = count;

	always_comb
	begin
		next_count = count;
		if (do_push && !do_pop)
			next_count = count + 1'b1;
		else if (do_pop && !do_push)
			next_count = count - 1'b1;
	end

	// Pointers, count and registered ready
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready_o <= next_count < (AW+1)'(DEPTH);
		end
	end

	// Storage, no reset needed on the data
	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule : lvsoc_fifo

// ### core/lvsoc_top.sv
// Purpose: serializers, sync lane, forwarded clock, divided clocks
//   and the serial register port of the sensor output stage
// Assumes: mclk_i and the serial port pins are asynchronous to clk_i
//   and are sampled by two flops; clk_i is well over 4x mclk_i
// Notes: every master edge is one bit slot; levels are flop outputs
`timescale 1ns/100ps
`include "lvsoc_map.svh"
module lvsoc_top #(
	parameter int LANES = 32,
	parameter int SYNC_LAT = `LVSOC_SYNC_LAT,
	parameter int DEPTH = `LVSOC_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Master input clock, sampled
	input wire logic mclk_i,
	// Converter words, one byte per lane
	input wire logic conv_valid_i,
	input wire logic [LANES*8-1:0] conv_data_i,
	output logic conv_ready_o,
	// Sequencer request for the sync lane
	input wire lvsoc_pkg::lvsoc_seq_t seq_i,
	// Serial lanes, true and complement legs
	output logic [LANES-1:0] lane_p_o,
	output logic [LANES-1:0] lane_n_o,
	output logic sync_p_o,
	output logic sync_n_o,
	output logic fclk_p_o,
	output logic fclk_n_o,
	// Derived clocks and driver settings
	output lvsoc_pkg::lvsoc_clks_t clks_o,
	output logic [3:0] drive_code_o,
	output logic [12:0] drive_ua_o,
	// Serial register port
	input wire logic spi_sclk_i,
	input wire logic spi_cs_b_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o
);
	import lvsoc_pkg::*;

	generate
		if (LANES < 1 || SYNC_LAT < 1 || DEPTH < 2)
		begin : g_bad
			$error("lvsoc_top: LANES, SYNC_LAT or DEPTH out of range");
		end
	endgenerate

	// Two-flop samplers for everything from outside the domain
	logic [3:0] in_s1;
	logic [3:0] in_s2;
	logic mclk_d;
	logic sclk_d;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			in_s1 <= 4'h4;
			in_s2 <= 4'h4;
			mclk_d <= 1'b0;
			sclk_d <= 1'b0;
		end
		else
		begin
			in_s1 <= {spi_mosi_i, spi_cs_b_i, spi_sclk_i, mclk_i};
			in_s2 <= in_s1;
			mclk_d <= in_s2[0];
			sclk_d <= in_s2[1];
		end
	end

	wire mclk_s = in_s2[0];
	wire sclk_s = in_s2[1];
	wire cs_b_s = in_s2[2];
	wire mosi_s = in_s2[3];
	wire m_rise = mclk_s && !mclk_d;
	wire m_fall = !mclk_s && mclk_d;
	wire slot = m_rise || m_fall;
	wire s_rise = sclk_s && !sclk_d && !cs_b_s;
	wire s_fall = !sclk_s && sclk_d && !cs_b_s;

	// Half-period counter: even on rising master edges, odd on falling
	logic [3:0] hp;
	logic [3:0] next_hp;
	always_comb
	begin
		next_hp = hp;
		if (m_rise)
			next_hp = {hp[3:1] + 3'h1, 1'b0};
		else if (m_fall)
			next_hp = {hp[3:1], 1'b1};
	end

	// Registers reached over the serial port
	logic [7:0] skew_reg;
	logic [7:0] drive_reg;
	logic underrun;

	// Skew codes limited to fifteen settings, one half period each
	wire [3:0] dly_sen = (skew_reg[3:0] > `LVSOC_SKEW_MAX) ?
		`LVSOC_SKEW_MAX : skew_reg[3:0];
	wire [3:0] dly_adc = (skew_reg[7:4] > `LVSOC_SKEW_MAX) ?
		`LVSOC_SKEW_MAX : skew_reg[7:4];
	wire [3:0] hp_sen = next_hp - dly_sen;
	wire [3:0] hp_adc = next_hp - dly_adc;
	wire load_slot = slot && next_hp[2:0] == 3'h0;

	// Derived clock levels, all updated from the same slot
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hp <= 4'h0;
			clks_o <= '0;
		end
		else if (slot)
		begin
			hp <= next_hp;
			clks_o.ser <= m_rise;
			clks_o.crc <= !next_hp[2];
			clks_o.load <= next_hp[2:0] == 3'h0;
			clks_o.adc <= !next_hp[3];
			clks_o.sensor <= !hp_sen[2];
			clks_o.adc_dly <= !hp_adc[3];
		end
	end

	// Converter words wait in the buffer; the load slot drains it
	logic fifo_valid;
	logic [LANES*8-1:0] fifo_word;
	logic [$clog2(DEPTH):0] fifo_level;
	lvsoc_fifo #(
		.W(LANES*8),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(conv_valid_i),
		.in_data_i(conv_data_i),
		.in_ready_o(conv_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_word),
		.out_ready_i(load_slot),
		.level_o(fifo_level)
	);

	// Per-lane shifter: load eight bits, then one bit per slot
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			logic [7:0] sh;
			wire [7:0] word = fifo_valid ? fifo_word[g*8 +: 8] :
				`LVSOC_W_DATA_IDLE;
			wire [7:0] next_sh = load_slot ? word :
				{sh[6:0], 1'b0};
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					sh <= 8'h00;
					lane_p_o[g] <= 1'b0;
					lane_n_o[g] <= 1'b1;
				end
				else if (slot)
				begin
					sh <= next_sh;
					lane_p_o[g] <= next_sh[7];
					lane_n_o[g] <= !next_sh[7];
				end
			end
		end
	endgenerate

	// Sync word coding from the sequencer request
	logic [7:0] seq_word;
	always_comb
	begin
		case (seq_i.kind)
			LVSOC_FRAME: seq_word = `LVSOC_W_FRAME;
			LVSOC_LINE_BEGIN: seq_word = `LVSOC_W_LINE_BEGIN;
			LVSOC_LINE_END: seq_word = `LVSOC_W_LINE_END;
			LVSOC_IDLE_FIRST: seq_word = `LVSOC_W_IDLE_FIRST;
			LVSOC_IDLE_SECOND: seq_word = `LVSOC_W_IDLE_SECOND;
			LVSOC_LINE_ADDR: seq_word = seq_i.addr;
			default: seq_word = `LVSOC_W_IDLE_FIRST;
		endcase
	end

	// Delay line of SYNC_LAT word slots matches converter latency
	logic [7:0] sync_dl [SYNC_LAT];
	logic [7:0] sync_sh;
	wire [7:0] next_sync = load_slot ? sync_dl[SYNC_LAT-1] :
		{sync_sh[6:0], 1'b0};
	generate
		for (g = 0; g < SYNC_LAT; g++)
		begin : g_sdl
			wire [7:0] src = (g == 0) ? seq_word : sync_dl[g == 0 ? 0 : g-1];
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
					sync_dl[g] <= `LVSOC_W_IDLE_FIRST;
				else if (load_slot)
					sync_dl[g] <= src;
			end
		end
	endgenerate

	// Sync lane and forwarded clock share the data lanes' slot
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync_sh <= 8'h00;
			sync_p_o <= 1'b0;
			sync_n_o <= 1'b1;
			fclk_p_o <= 1'b0;
			fclk_n_o <= 1'b1;
		end
		else if (slot)
		begin
			sync_sh <= next_sync;
			sync_p_o <= next_sync[7];
			sync_n_o <= !next_sync[7];
			fclk_p_o <= m_rise;
			fclk_n_o <= !m_rise;
		end
	end

	// Drive current in microamps follows the code in equal steps
	wire [12:0] next_ua = `LVSOC_DRV_BASE_UA +
		13'(drive_reg[3:0]) * `LVSOC_DRV_STEP_UA;
	wire starve = load_slot && !fifo_valid;

	// Serial port: write flag, 7-bit address, 8 data bits, MSB first
	lvsoc_spi_st_t spi_st;
	logic [2:0] bit_cnt;
	logic [7:0] rx;
	logic [6:0] addr;
	logic wr;
	logic [7:0] tx;
	wire [7:0] rd_data =
		(addr == `LVSOC_REG_SKEW) ? skew_reg :
		(addr == `LVSOC_REG_DRIVE) ? drive_reg :
		(addr == `LVSOC_REG_STATUS) ?
		{3'h0, underrun, 4'(fifo_level)} : 8'h00;
	wire head_done = spi_st == LVSOC_SPI_HEAD && s_rise &&
		bit_cnt == 3'h7;
	wire data_done = spi_st == LVSOC_SPI_DATA && s_rise &&
		bit_cnt == 3'h7;
	wire [7:0] rx_full = {rx[6:0], mosi_s};
	wire rd_status = data_done && !wr && addr == `LVSOC_REG_STATUS;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			spi_st <= LVSOC_SPI_IDLE;
			bit_cnt <= 3'h0;
			rx <= 8'h00;
			addr <= 7'h00;
			wr <= 1'b0;
			tx <= 8'h00;
		end
		else
		begin
			case (spi_st)
				LVSOC_SPI_IDLE:
				begin
					bit_cnt <= 3'h0;
					if (!cs_b_s)
						spi_st <= LVSOC_SPI_HEAD;
				end
				LVSOC_SPI_HEAD, LVSOC_SPI_DATA:
				begin
					if (s_rise)
					begin
						rx <= rx_full;
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (head_done)
					begin
						wr <= rx[6];
						addr <= rx_full[6:0];
						spi_st <= LVSOC_SPI_DATA;
					end
					if (data_done)
						spi_st <= LVSOC_SPI_HEAD;
					if (cs_b_s)
						spi_st <= LVSOC_SPI_IDLE;
				end
				default: spi_st <= LVSOC_SPI_IDLE;
			endcase
			// Read data is captured once the address is complete
			if (spi_st == LVSOC_SPI_DATA && s_fall)
				tx <= (bit_cnt == 3'h0) ? rd_data : {tx[6:0], 1'b0};
		end
	end

	// Register file, drive outputs and starvation flag
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			skew_reg <= `LVSOC_SKEW_RST;
			drive_reg <= `LVSOC_DRIVE_RST;
			underrun <= 1'b0;
			drive_code_o <= 4'h0;
			drive_ua_o <= 13'h0000;
			spi_miso_o <= 1'b0;
		end
		else
		begin
			if (data_done && wr && addr == `LVSOC_REG_SKEW)
				skew_reg <= rx_full;
			if (data_done && wr && addr == `LVSOC_REG_DRIVE)
				drive_reg <= rx_full;
			// A starved slot in the read cycle is still recorded
			if (starve)
				underrun <= 1'b1;
			else if (rd_status)
				underrun <= 1'b0;
			drive_code_o <= drive_reg[3:0];
			drive_ua_o <= next_ua;
			if (spi_st != LVSOC_SPI_DATA)
				spi_miso_o <= 1'b0;
			else if (s_fall)
				spi_miso_o <= (bit_cnt == 3'h0) ? rd_data[7] : tx[6];
		end
	end
endmodule : lvsoc_top

// ### sim/lvsoc_top_monitor.sv
// Purpose: port checks of the serial output block
// Assumes: bound into lvsoc_top, one clock domain
// Notes: a zero drive current means the register is not yet loaded
`timescale 1ns/100ps
module lvsoc_top_monitor #(
	parameter int LANES = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Watched ports
	input wire logic spi_cs_b_i,
	input wire logic spi_miso_o,
	input wire logic conv_ready_o,
	input wire logic [LANES-1:0] lane_p_o,
	input wire logic [LANES-1:0] lane_n_o,
	input wire logic sync_p_o,
	input wire logic sync_n_o,
	input wire logic fclk_p_o,
	input wire logic fclk_n_o,
	input wire lvsoc_pkg::lvsoc_clks_t clks_o,
	input wire logic [3:0] drive_code_o,
	input wire logic [12:0] drive_ua_o
);
	import lvsoc_pkg::*;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Legs of every pair are complements
	lane_compl_a: assert property (lane_n_o == ~lane_p_o)
		else $error("lane legs not complementary");
	sync_compl_a: assert property (sync_n_o == !sync_p_o)
		else $error("sync legs not complementary");
	fclk_compl_a: assert property (fclk_n_o == !fclk_p_o)
		else $error("clock legs not complementary");
	// Bits move only with a forwarded-clock edge
	edge_align_a: assert property ($changed(lane_p_o) || $changed(sync_p_o)
		|-> $changed(fclk_p_o))
		else $error("data moved without clock edge");
	ser_copy_a: assert property (clks_o.ser == fclk_p_o)
		else $error("serializer clock off master phase");
	load_slot_a: assert property (clks_o.load |-> fclk_p_o)
		else $error("load outside a rise slot");
	// Checksum and converter clocks switch only on master rise slots
	crc_rise_a: assert property ($changed(clks_o.crc) |->
		$rose(fclk_p_o))
		else $error("checksum clock off a rise slot");
	adc_rise_a: assert property ($changed(clks_o.adc) |->
		$rose(fclk_p_o))
		else $error("converter clock off a rise slot");
	drive_map_a: assert property (drive_ua_o != 13'h0 |->
		drive_ua_o == 13'h04ec + 13'h01a4 * drive_code_o)
		else $error("drive current not linear in code");
	miso_idle_a: assert property (spi_cs_b_i [*5] |-> !spi_miso_o)
		else $error("read data driven while deselected");
	load_c: cover property ($rose(clks_o.load));
	full_c: cover property (!conv_ready_o);
	drive_c: cover property ($changed(drive_code_o));
endmodule : lvsoc_top_monitor
bind lvsoc_top lvsoc_top_monitor #(.LANES(LANES)) u_lvsoc_top_monitor (.*);

// ### sim/lvsoc_rx_model.sv
// Purpose: far-end receiver for lanes 0, 31 and the sync lane
// Assumes: each bit slot lasts several clk_i cycles
// Notes: the load pulse frames words in place of a training pattern
`timescale 1ns/100ps
module lvsoc_rx_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Link
	input wire logic fclk_p_i,
	input wire logic [31:0] lane_p_i,
	input wire logic [31:0] lane_n_i,
	input wire logic sync_p_i,
	input wire logic load_i,
	input wire logic [3:0] drive_code_i,
	// Recovered words
	output logic got_o,
	output logic [23:0] word_o,
	output logic bad_o,
	output logic term_low_o
);
	logic fp;
	logic [23:0] sh;
	wire slot = fclk_p_i != fp;
	// Codes from 1000 up need the low-ohm board termination
	assign term_low_o = drive_code_i[3];
	// Both clock edges carry a bit; a load slot closes a word
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fp <= 1'b0;
			sh <= 24'h0;
			got_o <= 1'b0;
			word_o <= 24'h0;
			bad_o <= 1'b0;
		end
		else
		begin
			fp <= fclk_p_i;
			got_o <= slot & load_i;
			if (slot & load_i)
				word_o <= sh;
			if (slot)
				sh <= {sh[22:16], lane_p_i[31], sh[14:8], lane_p_i[0],
					sh[6:0], sync_p_i};
			bad_o <= bad_o | (lane_n_i != ~lane_p_i);
		end
	end
endmodule : lvsoc_rx_model

// ### sim/tb_top.sv
// Purpose: self-checking bench of the serial output block
// Assumes: 32 lanes; the receiver model watches lanes 0 and 31
// Notes: skew register is only read, never changed
`timescale 1ns/100ps
`include "lvsoc_map.svh"
module tb_top;
	import lvsoc_pkg::*;
	logic clk_i, rst_b_i, mclk_i, conv_valid_i, conv_ready_o;
	logic [255:0] conv_data_i;
	lvsoc_seq_t seq_i;
	logic [31:0] lane_p_o, lane_n_o;
	logic sync_p_o, sync_n_o, fclk_p_o, fclk_n_o, got, bad, term_low;
	lvsoc_clks_t clks_o;
	logic [3:0] drive_code_o;
	logic [12:0] drive_ua_o;
	logic spi_sclk_i, spi_cs_b_i, spi_mosi_i, spi_miso_o;
	logic [23:0] word;
	int err_count, num_checks;
	lvsoc_top u_lvsoc_top (.*);
	// Far-end receiver
	lvsoc_rx_model u_lvsoc_rx_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.fclk_p_i(fclk_p_o), .lane_p_i(lane_p_o), .lane_n_i(lane_n_o),
		.sync_p_i(sync_p_o), .load_i(clks_o.load),
		.drive_code_i(drive_code_o), .got_o(got), .word_o(word),
		.bad_o(bad), .term_low_o(term_low));
	// System clock 4 ns; master clock 64 ns, odd phase
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial
	begin
		mclk_i = 1'b0;
		#13.3;
		forever #32 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [15:0] g, e, input string s);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected at %0t: %s %h not %h", $time, s, g, e);
		end
	endtask : chk
	// One frame {write, address, data}; q keeps the last eight read bits
	task automatic spi(input logic [15:0] f, output logic [7:0] q);
		spi_cs_b_i <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			spi_mosi_i <= f[i];
			repeat (4) @(posedge clk_i);
			q = {q[6:0], spi_miso_o};
			spi_sclk_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			spi_sclk_i <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		spi_cs_b_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask : spi
	task automatic wword;
		for (int i = 0; i < 200; i++)
		begin
			@(posedge clk_i);
			if (got === 1'b1)
				return;
		end
		chk(16'h0, 16'h1, "word wait");
	endtask : wword
	task automatic t_regs;
		logic [7:0] q;
		chk(drive_code_o, 16'h0005, "code reset");
		spi(16'h4100, q);
		chk(q, 16'h0077, "skew");
		spi(16'h903c, q);
		spi(16'h1000, q);
		chk(q, 16'h0000, "unmapped");
		for (int c = 0; c < 16; c++)
		begin
			spi({8'hc8, 4'h0, c[3:0]}, q);
			chk(drive_code_o, c[15:0], "code");
			chk(drive_ua_o, 16'h04ec + 16'h01a4 * c[15:0], "ua");
			chk(term_low, 16'(c >= 8), "term");
		end
		spi(16'h4800, q);
		chk(q, 16'h000f, "readback");
	endtask : t_regs
	task automatic t_stream;
		int n, k;
		logic [7:0] b;
		logic [7:0] q;
		n = 0;
		k = 0;
		wword();
		conv_valid_i <= 1'b1;
		repeat (30)
		begin
			b = 8'h11 + n[7:0];
			conv_data_i <= {~b, {31{b}}};
			@(posedge clk_i);
			n += (conv_ready_o === 1'b1);
		end
		conv_valid_i <= 1'b0;
		chk(conv_ready_o, 16'h0, "ready");
		chk(n[15:0], 16'h0008, "taken");
		for (int i = 0; i < 40 && k <= n; i++)
		begin
			wword();
			b = 8'h11 + k[7:0];
			if (k > 0 || word[15:8] !== 8'h00)
			begin
				chk(word[23:8], (k < n) ? {~b, b} : 16'h0, "lanes");
				k++;
			end
		end
		chk(k[15:0], 16'h0009, "words");
		// Drained buffer starves every load slot: underrun set, level 0
		spi(16'h4900, q);
		chk(q, 16'h0010, "status");
		chk(bad, 16'h0, "legs");
	endtask : t_stream
	task automatic t_sync;
		logic [7:0] code [6];
		int c;
		code = '{`LVSOC_W_FRAME, `LVSOC_W_LINE_BEGIN, `LVSOC_W_LINE_END,
			`LVSOC_W_IDLE_FIRST, `LVSOC_W_IDLE_SECOND, 8'h5a};
		for (int i = 0; i < 6; i++)
		begin
			wword();
			seq_i <= '{lvsoc_sync_kind_t'(i[2:0]), 8'h5a};
			c = 0;
			do
			begin
				wword();
				c++;
			end
			while (word[7:0] !== code[i] && c < 20);
			chk(c[15:0], 16'(`LVSOC_SYNC_LAT + 2), "delay");
			chk(word[7:0], code[i], "sync");
		end
	endtask : t_sync
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Reset, then each scenario in turn
	initial
	begin
		err_count = 0;
		num_checks = 0;
		rst_b_i = 1'b0;
		conv_valid_i = 1'b0;
		conv_data_i = 256'h0;
		seq_i = '{LVSOC_IDLE_FIRST, 8'h00};
		spi_sclk_i = 1'b0;
		spi_cs_b_i = 1'b1;
		spi_mosi_i = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_regs();
		t_stream();
		t_sync();
		stop_test();
	end
	// The run needs about 40 us; a hang is cut at 200 us
	initial
	begin
		#200000;
		err_count++;
		stop_test();
	end
endmodule : tb_top
